// [rtl/gets_capture.v]
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "gets_map.vh"

// Summary of operation
// - A rising pin edge or manual capture loads the 32-bit seconds into the rise seconds register.
// - The same event loads 30 nanosecond bits into the rise nanoseconds register, top two bits zero.
// - A separate fall pair is loaded on a falling edge or manual capture, same widths.
// - Seconds and nanoseconds of one edge type form one timestamp and are read-only.
// - With the lock clear a new capture may land between reads of the two halves.
// - Capture registers appear only when the three-bit bank field selects the pin bank.
// - Accesses at the capture offsets go to the pin chosen by the three-bit pin select.
// - All eight per-pin register sets exist and reset to zero.
// - With the lock set and the flag already set, a new capture is discarded.
// - Edges capture only when enabled and every capture sets its event flag.
module gets_capture #(
    parameter PINS = 8
) (
    input  wire                  clk,
    input  wire                  rst_n,
    input  wire [PINS-1:0]       pin_in,
    input  wire [31:0]           stamp_seconds,
    input  wire [`GETS_NS_W-1:0] stamp_nanoseconds,
    input  wire                  wb_cyc_i,
    input  wire                  wb_stb_i,
    input  wire                  wb_we_i,
    input  wire [11:0]           wb_adr_i,
    input  wire [3:0]            wb_sel_i,
    input  wire [31:0]           wb_dat_i,
    output reg  [31:0]           wb_dat_o,
    output reg                   wb_ack_o,
    output reg                   irq_q
);

    reg [PINS-1:0]       pin_meta_q;
    reg [PINS-1:0]       pin_sync_q;
    reg [PINS-1:0]       pin_prev_q;
    reg [31:0]           rise_sec_q [0:PINS-1];
    reg [`GETS_NS_W-1:0] rise_ns_q  [0:PINS-1];
    reg [31:0]           fall_sec_q [0:PINS-1];
    reg [`GETS_NS_W-1:0] fall_ns_q  [0:PINS-1];
    reg [7:0]            rise_capture_on_q;
    reg [7:0]            fall_capture_on_q;
    reg [7:0]            rise_overwrite_lock_q;
    reg [7:0]            fall_overwrite_lock_q;
    reg [2:0]            pin_sel_q;
    reg [2:0]            bank_sel_q;
    reg [7:0]            pin_rise_event_flags_q;
    reg [7:0]            pin_fall_event_flags_q;
    reg [7:0]            rise_mask_q;
    reg [7:0]            fall_mask_q;
    reg [PINS-1:0]       rise_hit;
    reg [PINS-1:0]       fall_hit;
    reg [PINS-1:0]       rise_load;
    reg [PINS-1:0]       fall_load;
    reg [PINS-1:0]       man_rise;
    reg [PINS-1:0]       man_fall;
    reg [31:0]           rd_d;
    reg                  rd_ok;
    reg [7:0]            rise_flags_d;
    reg [7:0]            fall_flags_d;
    integer              i;
    integer              j;
    integer              k;

    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr  = req & wb_we_i & (&wb_sel_i);
    wire pin_bank = (bank_sel_q == `GETS_PIN_BANK);

    // Byte-lane merge for partially written control words
    function [31:0] gets_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        integer b;
        begin
            gets_merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    gets_merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // Full-address match against one register offset
    function gets_at;
        input [11:0] adr;
        input [11:0] off;
        begin
            gets_at = (adr == off);
        end
    endfunction

    wire wr_any = req & wb_we_i;
    wire [31:0] cfg_word = {5'h00, fall_overwrite_lock_q[2:0], 5'h00,
                            rise_overwrite_lock_q[2:0], 5'h00,
                            fall_capture_on_q[2:0], 5'h00,
                            rise_capture_on_q[2:0]};
    wire [31:0] cfg_new  = gets_merge(cfg_word, wb_dat_i, wb_sel_i);

    // Write strobes, one per writable register
    wire cfg_wr  = wr_any & gets_at(wb_adr_i, `GETS_CAP_CFG_OFF);
    wire sel_wr  = wr_any & gets_at(wb_adr_i, `GETS_BANK_SEL_OFF);
    wire sts_wr  = wr_any & gets_at(wb_adr_i, `GETS_EVT_STS_OFF);
    wire mask_wr = wr & gets_at(wb_adr_i, `GETS_EVT_MASK_OFF);
    wire man_wr  = wr_any & gets_at(wb_adr_i, `GETS_MANUAL_OFF);

    always @* begin
        man_rise = {PINS{1'b0}};
        man_fall = {PINS{1'b0}};
        if (man_wr) begin
            man_rise = wb_dat_i[`GETS_RISE_FLAG_LSB +: PINS];
            man_fall = wb_dat_i[`GETS_FALL_FLAG_LSB +: PINS];
        end
        for (j = 0; j < PINS; j = j + 1) begin
            rise_hit[j] = (pin_sync_q[j] & ~pin_prev_q[j]
                           & rise_capture_on_q[j]) | man_rise[j];
            fall_hit[j] = (~pin_sync_q[j] & pin_prev_q[j]
                           & fall_capture_on_q[j]) | man_fall[j];
            rise_load[j] = rise_hit[j] & ~(rise_overwrite_lock_q[j]
                           & pin_rise_event_flags_q[j]);
            fall_load[j] = fall_hit[j] & ~(fall_overwrite_lock_q[j]
                           & pin_fall_event_flags_q[j]);
        end
    end

    // Write-one clears; a capture in the same cycle wins
    always @* begin
        rise_flags_d = pin_rise_event_flags_q;
        fall_flags_d = pin_fall_event_flags_q;
        for (k = 0; k < 8; k = k + 1) begin
            if (sts_wr && wb_sel_i[0] && wb_dat_i[k]) begin
                rise_flags_d[k] = 1'b0;
            end
            if (sts_wr && wb_sel_i[1] && wb_dat_i[8+k]) begin
                fall_flags_d[k] = 1'b0;
            end
            if (k < PINS && rise_load[k]) begin
                rise_flags_d[k] = 1'b1;
            end
            if (k < PINS && fall_load[k]) begin
                fall_flags_d[k] = 1'b1;
            end
        end
    end

    always @* begin
        rd_d  = 32'h00000000;
        rd_ok = 1'b1;
        case (wb_adr_i)
            `GETS_CAP_CFG_OFF:  rd_d = cfg_word;
            `GETS_BANK_SEL_OFF: rd_d = {21'h000000, bank_sel_q, 5'h00,
                                        pin_sel_q};
            `GETS_EVT_STS_OFF:  rd_d = {16'h0000, pin_fall_event_flags_q,
                                        pin_rise_event_flags_q};
            `GETS_EVT_MASK_OFF: rd_d = {16'h0000, fall_mask_q, rise_mask_q};
            `GETS_MANUAL_OFF:   rd_d = 32'h00000000;
            // Capture pair of the selected pin, pin bank only
            `GETS_RISE_SEC_OFF: rd_d = pin_bank ?
                                rise_sec_q[pin_sel_q] : 32'h00000000;
            `GETS_RISE_NS_OFF:  rd_d = pin_bank ? {2'b00,
                                rise_ns_q[pin_sel_q]} : 32'h00000000;
            `GETS_FALL_SEC_OFF: rd_d = pin_bank ?
                                fall_sec_q[pin_sel_q] : 32'h00000000;
            `GETS_FALL_NS_OFF:  rd_d = pin_bank ? {2'b00,
                                fall_ns_q[pin_sel_q]} : 32'h00000000;
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            pin_meta_q <= {PINS{1'b0}};
            pin_sync_q <= {PINS{1'b0}};
            pin_prev_q <= {PINS{1'b0}};
            for (i = 0; i < PINS; i = i + 1) begin
                rise_sec_q[i] <= `GETS_CAP_RST;
                rise_ns_q[i]  <= {`GETS_NS_W{1'b0}};
                fall_sec_q[i] <= `GETS_CAP_RST;
                fall_ns_q[i]  <= {`GETS_NS_W{1'b0}};
            end
        end else begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
            for (i = 0; i < PINS; i = i + 1) begin
                if (rise_load[i]) begin
                    rise_sec_q[i] <= stamp_seconds;
                    rise_ns_q[i]  <= stamp_nanoseconds;
                end
                if (fall_load[i]) begin
                    fall_sec_q[i] <= stamp_seconds;
                    fall_ns_q[i]  <= stamp_nanoseconds;
                end
            end
        end
    end

    // Bus response: one wait state, read data only in the ack cycle
    always @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i && rd_ok) begin
                wb_dat_o <= rd_d;
            end else begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end

    // Only pins 0..2 carry enables and locks; pins 3..7 keep the
    // reset values, so they capture on manual command only
    always @(posedge clk) begin
        if (!rst_n) begin
            rise_capture_on_q     <= `GETS_ON_RST;
            fall_capture_on_q     <= `GETS_ON_RST;
            rise_overwrite_lock_q <= `GETS_LOCK_RST;
            fall_overwrite_lock_q <= `GETS_LOCK_RST;
        end else if (cfg_wr) begin
            rise_capture_on_q[2:0] <= cfg_new[`GETS_RISE_ON_LSB +: 3];
            fall_capture_on_q[2:0] <= cfg_new[`GETS_FALL_ON_LSB +: 3];
            rise_overwrite_lock_q[2:0] <=
                cfg_new[`GETS_RISE_LOCK_LSB +: 3];
            fall_overwrite_lock_q[2:0] <=
                cfg_new[`GETS_FALL_LOCK_LSB +: 3];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            pin_sel_q  <= 3'h0;
            bank_sel_q <= 3'h0;
        end else if (sel_wr) begin
            if (wb_sel_i[0]) begin
                pin_sel_q <= wb_dat_i[`GETS_PIN_SEL_LSB +: 3];
            end
            if (wb_sel_i[1]) begin
                bank_sel_q <= wb_dat_i[`GETS_BANK_LSB +: 3];
            end
        end
    end

    // Mask takes full-word writes only
    always @(posedge clk) begin
        if (!rst_n) begin
            rise_mask_q <= 8'h00;
            fall_mask_q <= 8'h00;
        end else if (mask_wr) begin
            rise_mask_q <= wb_dat_i[7:0];
            fall_mask_q <= wb_dat_i[15:8];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            pin_rise_event_flags_q <= 8'h00;
            pin_fall_event_flags_q <= 8'h00;
        end else begin
            pin_rise_event_flags_q <= rise_flags_d;
            pin_fall_event_flags_q <= fall_flags_d;
        end
    end

    // Level output one cycle behind the flags, kept registered so the
    // pin never glitches while a clear and a capture race
    always @(posedge clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |((pin_rise_event_flags_q & rise_mask_q)
                       | (pin_fall_event_flags_q & fall_mask_q));
        end
    end

endmodule

// [rtl/gets_map.vh]
`ifndef GETS_MAP_VH
`define GETS_MAP_VH
// Byte offsets within the capture unit
`define GETS_RISE_SEC_OFF   12'h16c
`define GETS_RISE_NS_OFF    12'h170
`define GETS_FALL_SEC_OFF   12'h178
`define GETS_FALL_NS_OFF    12'h17c
`define GETS_CAP_CFG_OFF    12'h15c
`define GETS_BANK_SEL_OFF   12'h160
`define GETS_EVT_STS_OFF    12'h164
`define GETS_EVT_MASK_OFF   12'h168
`define GETS_MANUAL_OFF     12'h174
// Field positions of the capture configuration word
`define GETS_RISE_ON_LSB    0
`define GETS_FALL_ON_LSB    8
`define GETS_RISE_LOCK_LSB  16
`define GETS_FALL_LOCK_LSB  24
// Field positions of the bank/pin select word
`define GETS_PIN_SEL_LSB    0
`define GETS_BANK_LSB       8
`define GETS_PIN_BANK       3'h3
// Field positions of the status word and manual command word
`define GETS_RISE_FLAG_LSB  0
`define GETS_FALL_FLAG_LSB  8
// Reset values and the nanosecond field width
`define GETS_CAP_RST        32'h00000000
`define GETS_LOCK_RST       8'hff
`define GETS_ON_RST         8'h00
`define GETS_NS_W           30
`endif

// [test/gets_monitor.sv]
`timescale 1ns/1ps
`include "gets_map.vh"
module gets_monitor #(
    parameter PINS = 8
) (
    input wire                  clk,
    input wire                  rst_n,
    input wire [PINS-1:0]       pin_in,
    input wire [31:0]           stamp_seconds,
    input wire [`GETS_NS_W-1:0] stamp_nanoseconds,
    input wire                  wb_cyc_i,
    input wire                  wb_stb_i,
    input wire                  wb_we_i,
    input wire [11:0]           wb_adr_i,
    input wire [3:0]            wb_sel_i,
    input wire [31:0]           wb_dat_i,
    input wire [31:0]           wb_dat_o,
    input wire                  wb_ack_o,
    input wire                  irq_q
);
    wire            rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    wire            wr = wb_cyc_i && wb_stb_i && wb_we_i;
    reg  [PINS-1:0] pin_q;
    reg  [3:0]      quiet_q;
    // An interrupt must trace back to a recent pin change or write
    always @(posedge clk) begin
        pin_q <= pin_in;
        if (!rst_n || wr || pin_in != pin_q)
            quiet_q <= 4'h0;
        else if (quiet_q != 4'hf)
            quiet_q <= quiet_q + 4'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    no_idle_ack_a: assert property (!(wb_cyc_i && wb_stb_i)
        |=> !wb_ack_o)
        else $error("ack without request");
    dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    ns_top_zero_a: assert property (rd && (wb_adr_i == `GETS_RISE_NS_OFF
        || wb_adr_i == `GETS_FALL_NS_OFF) |=> wb_dat_o[31:30] == 2'h0)
        else $error("nanosecond top bits set");
    unmapped_zero_a: assert property (rd && (wb_adr_i == 12'h000
        || wb_adr_i == `GETS_MANUAL_OFF) |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    wake_quiet_a: assert property ($rose(rst_n)
        |-> !wb_ack_o && !irq_q)
        else $error("outputs active after reset");
    irq_cause_a: assert property ($rose(irq_q) |-> quiet_q < 4'hc)
        else $error("interrupt without cause");
endmodule
bind gets_capture gets_monitor #(.PINS(PINS)) mon (
    .clk(clk), .rst_n(rst_n), .pin_in(pin_in),
    .stamp_seconds(stamp_seconds), .stamp_nanoseconds(stamp_nanoseconds),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_q(irq_q));

// [test/gets_pin_model.sv]
`timescale 1ns/1ps
module gets_pin_model (
    input  wire       clk,
    input  wire [7:0] want,
    output reg  [7:0] pins
);
    reg [3:0] hold_q = 4'h0;
    initial pins = 8'h00;
    // Each level is held 9 cycles, well past the minimum pulse width
    always @(posedge clk) begin
        if (hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
        end else if (want != pins) begin
            pins   <= want;
            hold_q <= 4'h8;
        end
    end
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
`include "gets_map.vh"
module tb_top;
    logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
    logic [11:0] adr = 0;
    logic [31:0] wd = 0, tick = 0, got, t0, k, dout;
    logic        ack, irq;
    logic [7:0]  want = 0;
    wire  [7:0]  pins;
    int          mismatches = 0, compares = 0;
    initial forever #4 clk = ~clk;
    always @(posedge clk) tick <= tick + 32'h1;
    gets_pin_model pm (.clk(clk), .want(want), .pins(pins));
    gets_capture dut (.clk(clk), .rst_n(rst_n), .pin_in(pins),
        .stamp_seconds(tick), .stamp_nanoseconds(tick[29:0] + 30'h5),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dout),
        .wb_ack_o(ack), .irq_q(irq));
    task automatic wrap_up;
        if (mismatches == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        wd  <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        got = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            wrap_up;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk($sformatf("reg %h", a), e, got);
    endtask
    // Time moves every cycle, so check the pair agrees and is recent
    task automatic cap(input logic [11:0] a);
        bus(a, 1'b0, 32'h0);
        k = got;
        chk("stamp age", 32'h1, 32'(k - t0 < 32'h20));
        rd(a + 12'h4, {2'h0, k[29:0] + 30'h5});
    endtask
    task automatic wt;
        repeat (12) @(posedge clk);
    endtask
    initial begin
        wt;
        rst_n <= 1'b1;
        rd(`GETS_CAP_CFG_OFF, 32'h07070000);
        for (int p = 0; p < 8; p++) begin
            bus(`GETS_BANK_SEL_OFF, 1'b1, 32'h300 + p);
            for (int r = 0; r < 4; r++)
                rd(12'h16c + 12'(4 * r + (r > 1) * 4), 32'h0);
        end
        bus(`GETS_RISE_SEC_OFF, 1'b1, 32'hffffffff);
        rd(`GETS_RISE_SEC_OFF, 32'h0);
        rd(12'h000, 32'h0);
        bus(`GETS_CAP_CFG_OFF, 1'b1, 32'h00000101);
        bus(`GETS_EVT_MASK_OFF, 1'b1, 32'h0000ffff);
        bus(`GETS_BANK_SEL_OFF, 1'b1, 32'h300);
        t0 = tick;
        want <= 8'h01;
        wt;
        rd(`GETS_EVT_STS_OFF, 32'h1);
        chk("irq", 32'h1, 32'(irq));
        cap(`GETS_RISE_SEC_OFF);
        rd(`GETS_FALL_SEC_OFF, 32'h0);
        t0 = tick;
        want <= 8'h02;
        wt;
        cap(`GETS_FALL_SEC_OFF);
        rd(`GETS_EVT_STS_OFF, 32'h101);
        t0 = tick;
        want <= 8'h03;
        wt;
        cap(`GETS_RISE_SEC_OFF);
        bus(`GETS_BANK_SEL_OFF, 1'b1, 32'h005);
        rd(`GETS_RISE_SEC_OFF, 32'h0);
        bus(`GETS_BANK_SEL_OFF, 1'b1, 32'h305);
        t0 = tick;
        bus(`GETS_MANUAL_OFF, 1'b1, 32'h20);
        cap(`GETS_RISE_SEC_OFF);
        t0 = k;
        bus(`GETS_MANUAL_OFF, 1'b1, 32'h20);
        rd(`GETS_RISE_SEC_OFF, t0);
        bus(`GETS_EVT_STS_OFF, 1'b1, 32'h0000ffff);
        rd(`GETS_EVT_STS_OFF, 32'h0);
        chk("irq", 32'h0, 32'(irq));
        t0 = tick;
        bus(`GETS_MANUAL_OFF, 1'b1, 32'h2020);
        cap(`GETS_FALL_SEC_OFF);
        bus(`GETS_EVT_MASK_OFF, 1'b1, 32'h0);
        wt;
        chk("irq", 32'h0, 32'(irq));
        wrap_up;
    end
endmodule
